/* File: include/flyback_law_pkg.sv */
package flyback_law_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 10_000_000;
  localparam int F_CEIL_HZ  = 85_000;
  localparam int F_FLOOR_HZ = 1_000;
  localparam int F_MID_HZ   = 25_000;
  localparam int F_HOLD_HZ  = 4_000;
  localparam int HOLD_MS    = 500;
  localparam int ZTO_NS     = 2_000;
  localparam int PER_W      = 24;

  // Shortest period rounds up, longest rounds down
  localparam int PER_CEIL_CYC  = (CLK_HZ + F_CEIL_HZ - 1) / F_CEIL_HZ;
  localparam int PER_FLOOR_CYC = CLK_HZ / F_FLOOR_HZ;
  localparam int PER_MID_CYC   = CLK_HZ / F_MID_HZ;
  localparam int PER_HOLD_CYC  = CLK_HZ / F_HOLD_HZ;
  localparam int HOLD_CYC      = (CLK_HZ / 1000) * HOLD_MS;
  localparam int ZTO_CYC       = (ZTO_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ----------------------------------------------------------------
  // Control-law levels in millivolts
  // ----------------------------------------------------------------
  localparam int MV_W      = 13;
  localparam int CL_MIN_MV = 1300;
  localparam int CL_CC_MV  = 4850;
  localparam int CL_23_MV  = 2000;
  localparam int CL_34_MV  = 3500;
  localparam int HYST_MV   = 50;
  localparam int OVP_MV    = 4670;
  localparam int OVP_COUNT = 3;

  // ----------------------------------------------------------------
  // Peak command, duty limit, cable compensation
  // ----------------------------------------------------------------
  localparam int PK_W       = 8;
  localparam logic [PK_W-1:0] PEAK_MAX     = 8'hFF;
  localparam logic [PK_W-1:0] PEAK_QUARTER = 8'h40;
  localparam int DUTY_NUM   = 19;
  localparam int DUTY_DEN   = 40;
  localparam int CC_STEP    = 16;
  localparam int CABLE_PCT  = 6;
  localparam int LOAD_W     = 8;

  typedef enum logic [1:0] {REG_LOW, REG_MID, REG_HEAVY, REG_CC} region_t;

endpackage

/* File: include/cycle_if.sv */
`timescale 1ns/1ps
interface cycle_if;
  import flyback_law_pkg::*;
  logic [PER_W-1:0] minPeriod;
  logic             run;
  logic             valley;
  logic             demag;
  logic             startCycle;
  logic             cycleDone;
  logic [PER_W-1:0] periodCnt;
  logic [PER_W-1:0] demagCnt;

  modport law   (output minPeriod, run, valley, demag,
                 input startCycle, cycleDone, periodCnt, demagCnt);
  modport timer (input minPeriod, run, valley, demag,
                 output startCycle, cycleDone, periodCnt, demagCnt);
endinterface

/* File: design/cycle_timer.sv */
`timescale 1ns/1ps
module cycle_timer
  import flyback_law_pkg::*;
(
  input logic   clk,
  input logic   rst,
  cycle_if.timer cyc
);

  logic [PER_W-1:0] cnt_q;
  logic [PER_W-1:0] demAcc_q;
  logic [PER_W-1:0] zto_q;
  logic             expired;
  logic             fire;
  logic             done_q;
  logic [PER_W-1:0] per_q;
  logic [PER_W-1:0] dem_q;

  // ----------------------------------------------------------------
  // Period timing: valley after expiry, else fixed timeout
  // ----------------------------------------------------------------
  assign expired = cnt_q >= cyc.minPeriod;
  assign fire    = cyc.run && expired && (cyc.valley || zto_q >= PER_W'(ZTO_CYC));

  always_ff @(posedge clk)
  begin
    if (rst || !cyc.run || fire)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst || !cyc.run || fire || !expired)
      zto_q <= '0;
    else
      zto_q <= zto_q + 1'b1;
  end

  // Demag time counted alongside the period every cycle
  always_ff @(posedge clk)
  begin
    if (rst || !cyc.run || fire)
      demAcc_q <= '0;
    else if (cyc.demag)
      demAcc_q <= demAcc_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_q <= 1'b0;
      per_q  <= '0;
      dem_q  <= '0;
    end
    else
    begin
      done_q <= fire;
      if (fire)
      begin
        per_q <= cnt_q + 1'b1;
        dem_q <= demAcc_q;
      end
    end
  end

  assign cyc.startCycle = fire;
  assign cyc.cycleDone  = done_q;
  assign cyc.periodCnt  = per_q;
  assign cyc.demagCnt   = dem_q;

  a_no_early_start : assert property (@(posedge clk) disable iff (rst)
    cyc.startCycle |-> cnt_q >= cyc.minPeriod) else $error("cycle started early");
  a_timeout_start : assert property (@(posedge clk) disable iff (rst)
    (cyc.run && expired && !cyc.valley && zto_q == PER_W'(ZTO_CYC)) |-> cyc.startCycle)
    else $error("timeout start missing");

endmodule

/* File: design/flyback_switching_control_law.sv */
`timescale 1ns/1ps
// Contract
// - The minimum period is clamped between the 85 kHz ceiling and the 1 kHz floor; the valley wait or timeout can stretch a cycle past the floor.
// - The control-law level from 1.3 V to 4.85 V selects the operating region automatically.
// - In the heavy region the peak command is at its maximum and only frequency varies.
// - In the medium region frequency is 25 kHz and the peak command spans 25% to 100%.
// - In the light region the peak command stays at one quarter while frequency drops.
// - A control-law level above 4.85 V puts the block into constant-current operation.
// - A demand below 4 kHz is held at 4 kHz for up to 500 ms or until output is 10% high.
// - In constant current, frequency drops so that demag duty stays at 0.475.
// - The voltage target rises with load, by 6% at the constant-current threshold.
// - The target rise applies only in constant-voltage operation.
// - In constant current, output or supply undervoltage stops switching.
// - A minimum period is enforced, then the cycle starts at the next valley.
// - With no valley after the minimum period, the cycle starts after a fixed timeout.
// - Feedback above 4.67 V on three consecutive cycles latches a fault and stops switching.
// - Below maximum peak command the block idles in a low-bias wait between pulses.
module flyback_switching_control_law
  import flyback_law_pkg::*;
#(
  parameter int PER_FLOOR = PER_FLOOR_CYC,
  parameter int HOLD_LEN  = HOLD_CYC,
  parameter int TH_23_MV  = CL_23_MV,
  parameter int TH_34_MV  = CL_34_MV,
  parameter int HYST      = HYST_MV
)
(
  input  logic                               clk,
  input  logic                               rst,
  input  logic [flyback_law_pkg::MV_W-1:0]   controlLawLevel,
  input  logic [flyback_law_pkg::MV_W-1:0]   feedbackSample,
  input  logic                               feedbackValid,
  input  logic [flyback_law_pkg::MV_W-1:0]   noLoadOutputSetpoint,
  input  logic [flyback_law_pkg::LOAD_W-1:0] loadFraction,
  input  logic                               currentTrip,
  input  logic                               valleyDetect,
  input  logic                               demagActive,
  input  logic                               outputLow,
  input  logic                               supplyLow,
  input  logic                               outputHigh,
  output logic                               gateDrive,
  output logic [flyback_law_pkg::PK_W-1:0]   peakPrimaryCurrent,
  output logic [flyback_law_pkg::MV_W-1:0]   outputTarget,
  output flyback_law_pkg::region_t           region,
  output logic                               waitState,
  output logic                               overvoltageFault,
  output logic                               ccShutdown
);
  import flyback_law_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 6;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinMeta_q;
  logic [NPIN-1:0] pinSync_q;
  assign pinRaw = {outputHigh, supplyLow, outputLow, demagActive, valleyDetect, currentTrip};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          pinMeta_q[gi] <= 1'b0;
          pinSync_q[gi] <= 1'b0;
        end
        else
        begin
          pinMeta_q[gi] <= pinRaw[gi];
          pinSync_q[gi] <= pinMeta_q[gi];
        end
      end
    end
  endgenerate

  logic tripS, valleyS, demagS, outLowS, supLowS, outHighS;
  assign {outHighS, supLowS, outLowS, demagS, valleyS, tripS} = pinSync_q;

  // ----------------------------------------------------------------
  // Region selection
  // ----------------------------------------------------------------
  region_t region_q;
  int      lvl;
  assign lvl = int'(controlLawLevel);

  always_ff @(posedge clk)
  begin
    if (rst)
      region_q <= REG_LOW;
    else
      case (region_q)
        REG_LOW:   if (lvl > TH_23_MV + HYST) region_q <= REG_MID;
        REG_MID:   if (lvl > TH_34_MV + HYST) region_q <= REG_HEAVY;
                   else if (lvl < TH_23_MV - HYST) region_q <= REG_LOW;
        REG_HEAVY: if (lvl > CL_CC_MV) region_q <= REG_CC;
                   else if (lvl < TH_34_MV - HYST) region_q <= REG_MID;
        REG_CC:    if (lvl < CL_CC_MV - HYST) region_q <= REG_HEAVY;
        default:   region_q <= REG_LOW;
      endcase
  end
  assign region = region_q;

  // Keeps the period inside the frequency ceiling and floor
  function automatic logic [PER_W-1:0] clampPer(input int p);
    if (p < PER_CEIL_CYC)
      return PER_W'(PER_CEIL_CYC);
    else if (p > PER_FLOOR)
      return PER_W'(PER_FLOOR);
    else
      return PER_W'(p);
  endfunction

  // ----------------------------------------------------------------
  // Period demand and peak command per region
  // ----------------------------------------------------------------
  logic [PER_W-1:0] ccPer_q;
  int               demand;
  logic [PK_W-1:0]  peakNext;
  int               span;

  always_comb
  begin
    demand   = PER_MID_CYC;
    peakNext = PEAK_MAX;
    span     = 0;
    case (region_q)
      REG_LOW:
      begin
        span = (lvl < CL_MIN_MV) ? 0 : lvl - CL_MIN_MV;
        if (span > TH_23_MV - CL_MIN_MV)
          span = TH_23_MV - CL_MIN_MV;
        demand   = PER_FLOOR - span * (PER_FLOOR - PER_MID_CYC) / (TH_23_MV - CL_MIN_MV);
        peakNext = PEAK_QUARTER;
      end
      REG_MID:
      begin
        span = (lvl < TH_23_MV) ? 0 : lvl - TH_23_MV;
        if (span > TH_34_MV - TH_23_MV)
          span = TH_34_MV - TH_23_MV;
        demand   = PER_MID_CYC;
        peakNext = PK_W'(int'(PEAK_QUARTER)
                 + span * int'(PEAK_MAX - PEAK_QUARTER) / (TH_34_MV - TH_23_MV));
      end
      REG_HEAVY:
      begin
        span = (lvl < TH_34_MV) ? 0 : lvl - TH_34_MV;
        if (span > CL_CC_MV - TH_34_MV)
          span = CL_CC_MV - TH_34_MV;
        demand   = PER_MID_CYC - span * (PER_MID_CYC - PER_CEIL_CYC) / (CL_CC_MV - TH_34_MV);
        peakNext = PEAK_MAX;
      end
      REG_CC:
      begin
        demand   = int'(ccPer_q);
        peakNext = PEAK_MAX;
      end
      default:
      begin
        demand   = PER_MID_CYC;
        peakNext = PEAK_MAX;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Load-step floor at 4 kHz
  // ----------------------------------------------------------------
  logic [31:0] holdCnt_q;
  logic        released_q;
  logic        slowDemand;
  logic [PER_W-1:0] period;
  assign slowDemand = demand > PER_HOLD_CYC;

  always_ff @(posedge clk)
  begin
    if (rst || !slowDemand)
    begin
      holdCnt_q  <= '0;
      released_q <= 1'b0;
    end
    else if (!released_q)
    begin
      holdCnt_q <= holdCnt_q + 1'b1;
      if (holdCnt_q >= 32'(HOLD_LEN - 1) || outHighS)
        released_q <= 1'b1;
    end
  end

  // Holding the floor trades a little overshoot for fewer deep dips
  assign period = (slowDemand && !released_q) ? PER_W'(PER_HOLD_CYC)
                                              : clampPer(demand);

  // ----------------------------------------------------------------
  // Constant-current duty limit
  // ----------------------------------------------------------------
  cycle_if cyc ();
  logic dutyOver;
  assign dutyOver = 32'(cyc.demagCnt) * DUTY_DEN >= 32'(cyc.periodCnt) * DUTY_NUM;

  always_ff @(posedge clk)
  begin
    if (rst || region_q != REG_CC)
      ccPer_q <= PER_W'(PER_CEIL_CYC);
    else if (cyc.cycleDone && dutyOver)
      ccPer_q <= clampPer(int'(ccPer_q) + CC_STEP);
    else if (cyc.cycleDone)
      ccPer_q <= clampPer(int'(ccPer_q) - CC_STEP);
  end

  // ----------------------------------------------------------------
  // Faults
  // ----------------------------------------------------------------
  logic [1:0] ovpCnt_q;
  logic       ovp_q;
  logic       ccStop_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      ovpCnt_q <= '0;
    else if (feedbackValid)
      ovpCnt_q <= (int'(feedbackSample) > OVP_MV) ?
                  ((ovpCnt_q == 2'(OVP_COUNT)) ? ovpCnt_q : ovpCnt_q + 1'b1) : '0;
  end

  // Latched until the supply collapses, as a restart cycle would
  always_ff @(posedge clk)
  begin
    if (rst)
      ovp_q <= 1'b0;
    else if (feedbackValid && int'(feedbackSample) > OVP_MV
             && ovpCnt_q == 2'(OVP_COUNT - 1))
      ovp_q <= 1'b1;
    else if (supLowS)
      ovp_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ccStop_q <= 1'b0;
    else if (region_q == REG_CC && (outLowS || supLowS))
      ccStop_q <= 1'b1;
    else if (region_q != REG_CC && !outLowS && !supLowS)
      ccStop_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Cycle timing and gate
  // ----------------------------------------------------------------
  logic run;
  logic gate_q;
  logic [PK_W-1:0] peak_q;
  assign run = !ovp_q && !ccStop_q;

  assign cyc.minPeriod = period;
  assign cyc.run       = run;
  assign cyc.valley    = valleyS;
  assign cyc.demag     = demagS;

  cycle_timer cycle_timer_inst (
    .clk (clk),
    .rst (rst),
    .cyc (cyc.timer)
  );

  always_ff @(posedge clk)
  begin
    if (rst || !run)
      gate_q <= 1'b0;
    else if (cyc.startCycle)
      gate_q <= 1'b1;
    else if (tripS)
      gate_q <= 1'b0;
  end

  // Peak command changes only at cycle start so a pulse sees one value
  always_ff @(posedge clk)
  begin
    if (rst)
      peak_q <= PEAK_QUARTER;
    else if (cyc.startCycle)
      peak_q <= peakNext;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [MV_W-1:0] target_q;
  logic            wait_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      target_q <= '0;
    else if (region_q == REG_CC)
      target_q <= noLoadOutputSetpoint;
    else
      target_q <= MV_W'(int'(noLoadOutputSetpoint) + int'(noLoadOutputSetpoint)
                  * int'(loadFraction) * CABLE_PCT / (100 * 255));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      wait_q <= 1'b0;
    else
      wait_q <= run && peak_q != PEAK_MAX && !gate_q && !demagS;
  end

  assign gateDrive          = gate_q;
  assign peakPrimaryCurrent = peak_q;
  assign outputTarget       = target_q;
  assign waitState          = wait_q;
  assign overvoltageFault   = ovp_q;
  assign ccShutdown         = ccStop_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_stop_then_idle;
    !run ##1 !gate_q;
  endsequence

  a_period_in_range : assert property (period >= PER_W'(PER_CEIL_CYC)
    && period <= PER_W'(PER_FLOOR)) else $error("period out of range");
  a_heavy_peak_max : assert property (region_q == REG_HEAVY && cyc.startCycle
    |=> peak_q == PEAK_MAX) else $error("heavy region peak not max");
  a_mid_fixed_freq : assert property (region_q == REG_MID && !slowDemand
    |-> period == PER_W'(PER_MID_CYC)) else $error("medium period wrong");
  a_low_quarter : assert property (region_q == REG_LOW && cyc.startCycle
    |=> peak_q == PEAK_QUARTER) else $error("light peak not quarter");
  a_cc_entry : assert property (region_q == REG_HEAVY && lvl > CL_CC_MV
    |=> region_q == REG_CC) else $error("no constant-current entry");
  a_hold_floor : assert property ($rose(slowDemand) |-> period == PER_W'(PER_HOLD_CYC))
    else $error("4 kHz floor not held");
  a_cc_stop : assert property (region_q == REG_CC && outLowS |=> s_stop_then_idle)
    else $error("cc undervoltage did not stop");
  a_ovp_blocks : assert property (ovp_q |=> (!gate_q && !cyc.startCycle) [*2])
    else $error("switching during fault");
  a_cc_duty : assert property (region_q == REG_CC && cyc.cycleDone && dutyOver
    && ccPer_q < PER_W'(PER_FLOOR - CC_STEP) |=> ccPer_q == $past(ccPer_q) + PER_W'(CC_STEP))
    else $error("duty limit did not slow");
  a_cv_target : assert property (region_q == REG_CC |=> target_q == $past(noLoadOutputSetpoint))
    else $error("target raised in cc");

endmodule

/* File: testbench/power_stage_model.sv */
`timescale 1ns/1ps
module power_stage_model (
  input  wire logic        clk,
  input  wire logic        gateDrive,
  input  wire logic        ringOff,
  input  wire logic [15:0] demagLen,
  output logic             currentTrip,
  output logic             valleyDetect,
  output logic             demagActive
);
  logic [15:0] cnt      = 16'h0000;
  logic        gatePrev = 1'b0;

  // ----------------------------------------------------------------
  // Switch, transformer and ringing
  // ----------------------------------------------------------------
  // Counts from the last gate edge: on-time ramps the current, off-time first
  // demagnetises, then rings with a valley every eighth cycle for as long as ringOff is low
  always @(posedge clk)
  begin
    gatePrev <= gateDrive;
    if (gateDrive != gatePrev)
      cnt <= 16'h0000;
    else
      cnt <= cnt + 16'h0001;
    // The count restarts on a gate edge, so its old value must not leak into that cycle
    currentTrip  <= gateDrive && (gateDrive == gatePrev) && (cnt >= 16'h0005);
    demagActive  <= !gateDrive && ((gateDrive != gatePrev) || (cnt < demagLen));
    valleyDetect <= !gateDrive && !ringOff && (gateDrive == gatePrev) && (cnt >= demagLen)
                    && (cnt[2:0] == 3'h7);
  end
endmodule

/* File: testbench/tb_flyback_switching_control_law.sv */
`timescale 1ns/1ps
module tb_flyback_switching_control_law;
  import flyback_law_pkg::*;
  localparam int PFLOOR = 5000;
  localparam int SLK    = 12;
  logic              clk                  = 1'b0;
  logic              rst                  = 1'b1;
  logic [MV_W-1:0]   controlLawLevel      = 13'h05DC;
  logic [MV_W-1:0]   feedbackSample       = 13'h0000;
  logic              feedbackValid        = 1'b0;
  logic [MV_W-1:0]   noLoadOutputSetpoint = 13'h1388;
  logic [LOAD_W-1:0] loadFraction         = 8'h00;
  logic              outputLow            = 1'b0;
  logic              supplyLow            = 1'b0;
  logic              outputHigh           = 1'b0;
  logic              ringOff              = 1'b0;
  logic [15:0]       demagLen             = 16'h0014;
  logic              gPrev                = 1'b0;
  logic              currentTrip;
  logic              valleyDetect;
  logic              demagActive;
  logic              gateDrive;
  logic [PK_W-1:0]   peakPrimaryCurrent;
  logic [MV_W-1:0]   outputTarget;
  region_t           region;
  logic              waitState;
  logic              overvoltageFault;
  logic              ccShutdown;
  int                cyc         = 0;
  int                lastRise    = 0;
  int                per         = 0;
  int                rises       = 0;
  int                waitCnt     = 0;
  int                errCount    = 0;
  int                comparisons = 0;

  always #50 clk = ~clk;

  flyback_switching_control_law #(.PER_FLOOR(PFLOOR), .HOLD_LEN(6000))
  flyback_switching_control_law_inst (
    .clk(clk), .rst(rst), .controlLawLevel(controlLawLevel), .feedbackSample(feedbackSample),
    .feedbackValid(feedbackValid), .noLoadOutputSetpoint(noLoadOutputSetpoint),
    .loadFraction(loadFraction), .currentTrip(currentTrip), .valleyDetect(valleyDetect),
    .demagActive(demagActive), .outputLow(outputLow), .supplyLow(supplyLow),
    .outputHigh(outputHigh), .gateDrive(gateDrive), .peakPrimaryCurrent(peakPrimaryCurrent),
    .outputTarget(outputTarget), .region(region), .waitState(waitState),
    .overvoltageFault(overvoltageFault), .ccShutdown(ccShutdown));

  power_stage_model power_stage_model_inst (
    .clk(clk), .gateDrive(gateDrive), .ringOff(ringOff), .demagLen(demagLen),
    .currentTrip(currentTrip), .valleyDetect(valleyDetect), .demagActive(demagActive));

  // ----------------------------------------------------------------
  // Period and wait-state bookkeeping
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    gPrev <= gateDrive;
    if (waitState === 1'b1)
      waitCnt <= waitCnt + 1;
    if (gateDrive === 1'b1 && gPrev === 1'b0)
    begin
      per <= cyc - lastRise;
      lastRise <= cyc;
      rises <= rises + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      errCount++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, msg, seen, exp);
    end
  endtask

  task automatic nextPeriods(input int n);
    int r0;
    r0 = rises;
    for (int i = 0; i < 40000 && rises < r0 + n; i++)
      @(negedge clk);
  endtask

  task automatic setLevel(input int mv, input int n);
    @(negedge clk);
    controlLawLevel = MV_W'(mv);
    repeat (10) @(negedge clk);
    nextPeriods(n);
  endtask

  task automatic testReset;
    check(32'(gateDrive), 32'h0, "gate");
    check(32'(peakPrimaryCurrent), 32'(PEAK_QUARTER), "peak");
    check(32'(outputTarget), 32'h0, "target");
    check(32'(region), 32'(REG_LOW), "region");
    check(32'(waitState), 32'h0, "wait");
    check(32'({overvoltageFault, ccShutdown}), 32'h0, "faults");
    $display("reset test done");
  endtask

  task automatic testRegions;
    int      lv [9] = '{2700, 1980, 1500, 4000, 3480, 4900, 4820, 4000, 2700};
    region_t rg [9] = '{REG_MID, REG_MID, REG_LOW, REG_HEAVY, REG_HEAVY, REG_CC, REG_CC,
                        REG_HEAVY, REG_MID};
    for (int i = 0; i < 9; i++)
    begin
      setLevel(lv[i], 0);
      check(32'(region), 32'(rg[i]), "region");
    end
    $display("region test done");
  endtask

  task automatic testCeiling;
    int w0;
    int slow;
    setLevel(3600, 3);
    slow = per;
    w0 = waitCnt;
    setLevel(4840, 3);
    check(32'(per >= PER_CEIL_CYC), 32'h1, "ceiling");
    check(32'(per < slow), 32'h1, "heavy frequency");
    check(32'(peakPrimaryCurrent), 32'(PEAK_MAX), "heavy peak");
    check(32'(waitCnt == w0), 32'h1, "no wait at max peak");
    $display("ceiling test done");
  endtask

  task automatic testValley;
    int w0;
    setLevel(2700, 3);
    check(32'(per >= PER_MID_CYC && per <= PER_MID_CYC + SLK), 32'h1, "mid");
    w0 = waitCnt;
    nextPeriods(1);
    check(32'(waitCnt > w0), 32'h1, "wait");
    ringOff = 1'b1;
    nextPeriods(3);
    check(32'(per >= PER_MID_CYC + ZTO_CYC && per <= PER_MID_CYC + ZTO_CYC + 6), 32'h1,
          "timeout");
    ringOff = 1'b0;
    $display("valley test done");
  endtask

  task automatic testCable;
    loadFraction = 8'hFF;
    nextPeriods(2);
    check(32'(outputTarget), 32'd5300, "full comp");
    loadFraction = 8'h00;
    nextPeriods(2);
    check(32'(outputTarget), 32'd5000, "no comp");
    loadFraction = 8'hFF;
    setLevel(4900, 2);
    check(32'(outputTarget), 32'd5000, "cc comp");
    setLevel(2700, 2);
    $display("cable test done");
  endtask

  task automatic testOvp;
    int mv [6] = '{4700, 4700, 4670, 4700, 4700, 4700};
    int r0;
    for (int i = 0; i < 6; i++)
    begin
      check(32'(overvoltageFault), 32'h0, "early fault");
      nextPeriods(1);
      @(negedge clk);
      feedbackSample = MV_W'(mv[i]);
      feedbackValid = 1'b1;
      @(negedge clk);
      feedbackValid = 1'b0;
    end
    repeat (3) @(negedge clk);
    check(32'(overvoltageFault), 32'h1, "fault");
    r0 = rises;
    repeat (2000) @(negedge clk);
    check(32'(rises - r0), 32'h0, "stopped");
    supplyLow = 1'b1;
    repeat (5) @(negedge clk);
    supplyLow = 1'b0;
    repeat (5) @(negedge clk);
    check(32'(overvoltageFault), 32'h0, "fault cleared");
    $display("overvoltage test done");
  endtask

  task automatic testCcuv;
    int r0;
    for (int i = 0; i < 2; i++)
    begin
      setLevel(4900, 2);
      outputLow = (i == 0);
      supplyLow = (i == 1);
      repeat (10) @(negedge clk);
      r0 = rises;
      check(32'(ccShutdown), 32'h1, "cc stop");
      repeat (1000) @(negedge clk);
      check(32'(rises - r0), 32'h0, "cc no switching");
      outputLow = 1'b0;
      supplyLow = 1'b0;
      setLevel(2700, 2);
      check(32'(ccShutdown), 32'h0, "cc resume");
    end
    $display("cc undervoltage test done");
  endtask

  task automatic testDuty;
    demagLen = 16'd300;
    setLevel(4900, 40);
    check(32'(per >= 600 && per <= PFLOOR), 32'h1, "duty limit");
    demagLen = 16'h0014;
    setLevel(2700, 2);
    $display("duty test done");
  endtask

  task automatic testHold;
    setLevel(1300, 2);
    check(32'(per >= PER_HOLD_CYC && per <= PER_HOLD_CYC + SLK), 32'h1, "hold");
    check(32'(peakPrimaryCurrent), 32'(PEAK_QUARTER), "low peak");
    nextPeriods(4);
    check(32'(per >= PFLOOR && per <= PFLOOR + SLK), 32'h1, "floor");
    setLevel(2700, 2);
    outputHigh = 1'b1;
    setLevel(1300, 2);
    check(32'(per >= PFLOOR && per <= PFLOOR + SLK), 32'h1, "early release");
    outputHigh = 1'b0;
    $display("hold test done");
  endtask

  task automatic completeRun;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole sequence needs roughly 70k cycles
  initial
  begin
    #(95000 * 100);
    errCount++;
    $display("mismatch at %0t: watchdog expired", $time);
    completeRun();
  end

  initial
  begin
    repeat (4) @(negedge clk);
    testReset();
    repeat (5) @(negedge clk);
    rst = 1'b0;
    testRegions();
    testCeiling();
    testValley();
    testCable();
    testOvp();
    testCcuv();
    testDuty();
    testHold();
    completeRun();
  end
endmodule
